// ---- common/tmc_pkg.sv ----
// Purpose: Shared constants, types and helpers of the trunk module TDM control link.
// Assumes: One 25 MHz clock for both ends; ten-bit channel words, MSB first.
// Notes: Word layout is sample[7:0], supervisory bit, even parity bit.
package tmc_pkg;
	localparam int CLK_KHZ = 25000;
	localparam int LINK_KBPS = 2560;
	// Longest bit period that fits the link rate, so the divider rounds down.
	localparam int BIT_CYC = CLK_KHZ / LINK_KBPS;
	localparam logic [3:0] DIV_LAST = 4'(BIT_CYC - 1);
	localparam int N_CH = 32;
	localparam int N_TRUNK = 30;
	localparam int SCAN_FRAMES = 40;
	localparam int SCAN_MS = 5;
	localparam logic [3:0] POS_LAST = 4'h9;
	localparam logic [4:0] CH_LAST = 5'h1F;
	localparam logic [4:0] MSG_CH = 5'h00;
	localparam logic [4:0] SCAN_CH = 5'h10;
	localparam logic [5:0] FRM_LAST = 6'(SCAN_FRAMES - 1);
	localparam logic [5:0] SCAN_LAST = 6'(N_TRUNK - 1);
	localparam logic [4:0] TRUNK_LIMIT = 5'(N_TRUNK);
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [7:0] MAP_RST = 8'h00;
	localparam logic PLANE_RST = 1'b0;
	// Channel map entry fields.
	localparam int MAP_VLD = 5;
	localparam int MAP_TONE = 6;
	localparam int MAP_REPL = 7;
	// Processor port addresses.
	localparam logic [5:0] A_MAP = 6'h00;
	localparam logic [5:0] A_LOOP = 6'h20;
	localparam logic [5:0] A_ERR = 6'h24;
	localparam logic [5:0] A_PLANE = 6'h25;
	localparam logic [5:0] A_TXMSG = 6'h26;
	localparam logic [5:0] A_MSG0 = 6'h27;
	localparam logic [5:0] A_MSG1 = 6'h28;
	localparam logic [5:0] A_CARD = 6'h29;
	localparam logic [5:0] A_SCAN = 6'h2A;
	// Message class in the top two bits of a control byte.
	localparam logic [1:0] MT_TRUNK = 2'h0;
	localparam logic [1:0] MT_NET = 2'h1;
	localparam logic [1:0] MT_INTEG = 2'h2;
	typedef logic [8:0] tmc_word_t;

	function automatic logic [7:0] tmc_tone(input logic [2:0] idx);
		unique case (idx)
			3'h0: return 8'h80;
			3'h1: return 8'hDA;
			3'h2: return 8'hFF;
			3'h3: return 8'hDA;
			3'h4: return 8'h80;
			3'h5: return 8'h25;
			3'h6: return 8'h00;
			3'h7: return 8'h25;
		endcase
	endfunction

	function automatic logic [9:0] tmc_frame(input tmc_word_t w);
		return {w, ^w};
	endfunction
endpackage

// ---- common/tmc_link_if.sv ----
// Purpose: Serial TDM link between the network planes and the trunk module.
// Assumes: Network end owns bit and frame timing; both ends share one clock.
// Notes: dn and up carry one bit per plane.
`timescale 1ns/10ps
interface tmc_link_if;
	logic bit_stb;
	logic frm_sync;
	logic [1:0] dn;
	logic [1:0] up;
	modport dev (input bit_stb, input frm_sync, input dn, output up);
	modport net (output bit_stb, output frm_sync, output dn, input up);
endinterface

// ---- hdl/tmc_network_end.sv ----
// Purpose: Network plane end: makes link timing, sends and receives channel words.
// Assumes: User supplies the word for net_ch_o in time for the channel start.
// Notes: Both planes carry the same words; parity can be spoiled per plane.
`timescale 1ns/10ps
module tmc_network_end
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Link
	tmc_link_if.net link,
	// Transmit words
	output logic [4:0] net_ch_o,
	input wire tmc_pkg::tmc_word_t net_tx_word_i,
	input wire logic [1:0] net_par_flip_i,
	// Received words
	output logic [1:0][8:0] net_rx_word_o,
	output logic [4:0] net_rx_ch_o,
	output logic net_rx_stb_o,
	output logic [1:0] net_rx_perr_o
);
	logic [3:0] div_reg, div_next, pos_reg, pos_next;
	logic [4:0] ch_reg, ch_next, nch_reg, nch_next, rch_reg, rch_next;
	logic stb_reg, stb_next, sync_reg, sync_next, run_reg, run_next, rstb_reg, rstb_next;
	logic [1:0] dn_reg, dn_next, perr_reg, perr_next;
	logic [1:0][9:0] tx_reg, tx_next, rx_reg, rx_next;
	logic [1:0][8:0] rw_reg, rw_next;

	always_comb begin
		div_next = div_reg;
		pos_next = pos_reg;
		ch_next = ch_reg;
		nch_next = nch_reg;
		rch_next = rch_reg;
		stb_next = 1'b0;
		sync_next = 1'b0;
		run_next = run_reg;
		rstb_next = 1'b0;
		dn_next = dn_reg;
		perr_next = perr_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		rw_next = rw_reg;
		if (div_reg == DIV_LAST) begin
			div_next = 4'h0;
			stb_next = 1'b1;
			pos_next = (pos_reg == POS_LAST) ? 4'h0 : pos_reg + 4'h1;
			if (pos_reg == POS_LAST) begin
				ch_next = ch_reg + 5'h01;
				nch_next = ch_reg + 5'h02;
				sync_next = (ch_reg == CH_LAST);
				// The far end answers one clock late, inside the same bit, so its channel ends here.
				rstb_next = run_reg;
				rch_next = ch_reg;
				if (ch_reg == CH_LAST) begin
					run_next = 1'b1;
				end
			end
			for (int p = 0; p < 2; p++) begin
				rx_next[p] = {rx_reg[p][8:0], link.up[p]};
				if (pos_reg == POS_LAST) begin
					tx_next[p] = tmc_frame(net_tx_word_i) ^ {9'h000, net_par_flip_i[p]};
					dn_next[p] = tx_next[p][9];
					rw_next[p] = rx_next[p][9:1];
					perr_next[p] = ^rx_next[p];
				end else begin
					dn_next[p] = tx_reg[p][4'h8 - pos_reg];
				end
			end
		end else begin
			div_next = div_reg + 4'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_reg <= 4'h0;
			pos_reg <= POS_LAST;
			ch_reg <= CH_LAST;
			nch_reg <= MSG_CH;
			rch_reg <= MSG_CH;
			stb_reg <= 1'b0;
			sync_reg <= 1'b0;
			run_reg <= 1'b0;
			rstb_reg <= 1'b0;
			dn_reg <= 2'h0;
			perr_reg <= 2'h0;
			tx_reg <= '0;
			rx_reg <= '0;
			rw_reg <= '0;
		end else begin
			div_reg <= div_next;
			pos_reg <= pos_next;
			ch_reg <= ch_next;
			nch_reg <= nch_next;
			rch_reg <= rch_next;
			stb_reg <= stb_next;
			sync_reg <= sync_next;
			run_reg <= run_next;
			rstb_reg <= rstb_next;
			dn_reg <= dn_next;
			perr_reg <= perr_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			rw_reg <= rw_next;
		end
	end

	assign link.bit_stb = stb_reg;
	assign link.frm_sync = sync_reg;
	assign link.dn = dn_reg;
	assign net_ch_o = nch_reg;
	assign net_rx_word_o = rw_reg;
	assign net_rx_ch_o = rch_reg;
	assign net_rx_stb_o = rstb_reg;
	assign net_rx_perr_o = perr_reg;
endmodule // tmc_network_end

// ---- hdl/tmc_trunk_end.sv ----
// Purpose: Trunk module control end: link timing, message split, trunk scan, tones, looparound.
// Assumes: Link timing comes from the network end; processor is master of the small port.
// Notes: Transmit samples are buffered and sent one frame after capture.
`timescale 1ns/10ps
module tmc_trunk_end
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Link toward both network planes
	tmc_link_if.dev link,
	// Processor port
	input wire logic [5:0] proc_addr_i,
	input wire logic [7:0] proc_wdata_i,
	input wire logic proc_wr_i,
	input wire logic proc_rd_i,
	output logic [7:0] proc_rdata_o,
	output logic [1:0] par_err_o,
	// Trunk buses
	output logic [tmc_pkg::N_TRUNK-1:0] trunk_en_o,
	output logic [7:0] receive_data_bus_o,
	output logic receive_sup_o,
	input wire logic [7:0] transmit_data_bus_i,
	input wire logic transmit_sup_i,
	// Group codec
	output logic [4:0] codec_trunk_o,
	output logic codec_stb_o,
	// Trunk scan
	output logic [4:0] scan_trunk_o,
	output logic scan_stb_o,
	output logic [7:0] scan_wdata_o,
	input wire logic [7:0] scan_rdata_i,
	input wire logic [7:0] card_id_i,
	// Message controllers
	output logic msg_trunk_stb_o,
	output logic msg_net_stb_o,
	output logic msg_integ_stb_o,
	output logic [7:0] msg_data_o
);
	logic seen_reg, seen_next, plane_reg, plane_next, pend_reg, pend_next;
	logic [3:0] pos_reg, pos_next, cp;
	logic [4:0] ch_reg, ch_next, cc, trk;
	logic [5:0] frm_reg, frm_next;
	logic [1:0][9:0] sh_reg, sh_next;
	logic [1:0] err_reg, err_next, up_reg, up_next, err_set;
	logic [7:0] map_reg [N_CH];
	logic [7:0] map_next [N_CH];
	tmc_word_t txb_reg [N_CH];
	tmc_word_t txb_next [N_CH];
	logic [31:0] loop_reg, loop_next;
	logic [7:0] txmsg_reg, txmsg_next, card_reg, card_next, ent, smp, tone, rdata_reg, rdata_next;
	logic [1:0][7:0] msg_reg, msg_next;
	logic [8:0] sum;
	logic [9:0] txw;
	logic spch_reg, spch_next, scn_reg, scn_next, sup_reg, sup_next, cstb_reg, cstb_next;
	logic [4:0] sch_reg, sch_next, strk_reg, strk_next, ctrk_reg, ctrk_next, scan_reg, scan_next;
	logic [N_TRUNK-1:0] en_reg, en_next;
	logic [7:0] rxb_reg, rxb_next, swd_reg, swd_next, mdat_reg, mdat_next;
	logic sstb_reg, sstb_next;
	logic [2:0] mstb_reg, mstb_next;

	always_comb begin
		seen_next = seen_reg;
		plane_next = plane_reg;
		pend_next = pend_reg;
		pos_next = pos_reg;
		ch_next = ch_reg;
		frm_next = frm_reg;
		sh_next = sh_reg;
		up_next = up_reg;
		err_set = 2'h0;
		map_next = map_reg;
		txb_next = txb_reg;
		loop_next = loop_reg;
		txmsg_next = txmsg_reg;
		card_next = card_reg;
		msg_next = msg_reg;
		rdata_next = rdata_reg;
		spch_next = spch_reg;
		scn_next = scn_reg;
		sch_next = sch_reg;
		strk_next = strk_reg;
		ctrk_next = ctrk_reg;
		scan_next = scan_reg;
		en_next = en_reg;
		rxb_next = rxb_reg;
		sup_next = sup_reg;
		swd_next = swd_reg;
		mdat_next = mdat_reg;
		cstb_next = 1'b0;
		sstb_next = 1'b0;
		mstb_next = 3'h0;
		ent = map_reg[ch_reg];
		trk = ent[4:0];
		smp = 8'h00;
		tone = tmc_tone(frm_reg[2:0]);
		sum = 9'h000;
		txw = 10'h000;
		// Bit and channel position of the bit arriving at this strobe.
		if (link.frm_sync) begin
			cp = 4'h0;
			cc = MSG_CH;
		end else if (pos_reg == POS_LAST) begin
			cp = 4'h0;
			cc = ch_reg + 5'h01;
		end else begin
			cp = pos_reg + 4'h1;
			cc = ch_reg;
		end
		if (link.bit_stb && (link.frm_sync || seen_reg)) begin
			seen_next = 1'b1;
			pos_next = cp;
			ch_next = cc;
			if (link.frm_sync && seen_reg) begin
				frm_next = (frm_reg == FRM_LAST) ? 6'h00 : frm_reg + 6'h01;
				scan_next = frm_next[4:0];
			end
			txw = (cc == MSG_CH) ? tmc_frame({pend_reg ? txmsg_reg : IDLE_BYTE, 1'b0})
				: tmc_frame(txb_reg[cc]);
			up_next = {2{txw[4'h9 - cp]}};
			for (int p = 0; p < 2; p++) begin
				sh_next[p] = {sh_reg[p][8:0], link.dn[p]};
			end
			if (cp == POS_LAST) begin
				ent = map_reg[cc];
				trk = ent[4:0];
				for (int p = 0; p < 2; p++) begin
					err_set[p] = ^sh_next[p];
				end
				smp = sh_next[plane_reg][9:2];
				sch_next = cc;
				if (cc == MSG_CH) begin
					msg_next[0] = sh_next[0][9:2];
					msg_next[1] = sh_next[1][9:2];
					mdat_next = smp;
					mstb_next = {smp[7:6] == MT_INTEG, smp[7:6] == MT_NET, smp[7:6] == MT_TRUNK};
					pend_next = 1'b0;
				end else if (cc == SCAN_CH) begin
					if (frm_reg <= SCAN_LAST) begin
						sstb_next = 1'b1;
						swd_next = smp;
						scn_next = 1'b1;
					end
				end else if (ent[MAP_VLD] && trk < TRUNK_LIMIT) begin
					for (int t = 0; t < N_TRUNK; t++) begin
						en_next[t] = (trk == 5'(t));
					end
					sum = {1'b0, smp} + {1'b0, tone};
					rxb_next = !ent[MAP_TONE] ? smp : ent[MAP_REPL] ? tone
						: (sum[8] ? 8'hFF : sum[7:0]);
					sup_next = sh_next[plane_reg][1];
					ctrk_next = trk;
					cstb_next = 1'b1;
					strk_next = trk;
					spch_next = 1'b1;
				end else begin
					txb_next[cc] = {IDLE_BYTE, 1'b0};
				end
			end else if (cp == 4'h0) begin
				// One bit period after the delivery the trunk answer is taken.
				if (spch_reg) begin
					txb_next[sch_reg] = loop_reg[strk_reg] ? {rxb_reg, sup_reg}
						: {transmit_data_bus_i, transmit_sup_i};
					en_next = '0;
					spch_next = 1'b0;
				end
				if (scn_reg) begin
					txb_next[SCAN_CH] = {scan_rdata_i, 1'b0};
					card_next = card_id_i;
					scn_next = 1'b0;
				end
			end
		end
		if (proc_wr_i) begin
			if (!proc_addr_i[5]) begin
				map_next[proc_addr_i[4:0]] = proc_wdata_i;
			end else if (proc_addr_i[5:2] == A_LOOP[5:2]) begin
				loop_next[{proc_addr_i[1:0], 3'h0} +: 8] = proc_wdata_i;
			end else if (proc_addr_i == A_PLANE) begin
				plane_next = proc_wdata_i[0];
			end else if (proc_addr_i == A_TXMSG) begin
				txmsg_next = proc_wdata_i;
				pend_next = 1'b1;
			end
		end
		// A parity error in the same cycle as a clear still sets the flag.
		err_next = err_reg & ~((proc_wr_i && proc_addr_i == A_ERR) ? proc_wdata_i[1:0] : 2'h0);
		err_next = err_next | err_set;
		if (proc_rd_i) begin
			if (!proc_addr_i[5]) begin
				rdata_next = map_reg[proc_addr_i[4:0]];
			end else if (proc_addr_i[5:2] == A_LOOP[5:2]) begin
				rdata_next = loop_reg[{proc_addr_i[1:0], 3'h0} +: 8];
			end else begin
				unique case (proc_addr_i)
					A_ERR: rdata_next = {6'h00, err_reg};
					A_PLANE: rdata_next = {7'h00, plane_reg};
					A_TXMSG: rdata_next = {7'h00, pend_reg};
					A_MSG0: rdata_next = msg_reg[0];
					A_MSG1: rdata_next = msg_reg[1];
					A_CARD: rdata_next = card_reg;
					A_SCAN: rdata_next = {3'h0, scan_reg};
					default: rdata_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seen_reg <= 1'b0;
			plane_reg <= PLANE_RST;
			pend_reg <= 1'b0;
			pos_reg <= POS_LAST;
			ch_reg <= CH_LAST;
			frm_reg <= 6'h00;
			sh_reg <= '0;
			err_reg <= 2'h0;
			up_reg <= 2'h0;
			for (int i = 0; i < N_CH; i++) begin
				map_reg[i] <= MAP_RST;
				txb_reg[i] <= {IDLE_BYTE, 1'b0};
			end
			loop_reg <= 32'h0000_0000;
			txmsg_reg <= IDLE_BYTE;
			card_reg <= 8'h00;
			msg_reg <= '0;
			rdata_reg <= 8'h00;
			spch_reg <= 1'b0;
			scn_reg <= 1'b0;
			sch_reg <= 5'h00;
			strk_reg <= 5'h00;
			ctrk_reg <= 5'h00;
			scan_reg <= 5'h00;
			en_reg <= '0;
			rxb_reg <= 8'h00;
			sup_reg <= 1'b0;
			swd_reg <= 8'h00;
			mdat_reg <= 8'h00;
			cstb_reg <= 1'b0;
			sstb_reg <= 1'b0;
			mstb_reg <= 3'h0;
		end else begin
			seen_reg <= seen_next;
			plane_reg <= plane_next;
			pend_reg <= pend_next;
			pos_reg <= pos_next;
			ch_reg <= ch_next;
			frm_reg <= frm_next;
			sh_reg <= sh_next;
			err_reg <= err_next;
			up_reg <= up_next;
			map_reg <= map_next;
			txb_reg <= txb_next;
			loop_reg <= loop_next;
			txmsg_reg <= txmsg_next;
			card_reg <= card_next;
			msg_reg <= msg_next;
			rdata_reg <= rdata_next;
			spch_reg <= spch_next;
			scn_reg <= scn_next;
			sch_reg <= sch_next;
			strk_reg <= strk_next;
			ctrk_reg <= ctrk_next;
			scan_reg <= scan_next;
			en_reg <= en_next;
			rxb_reg <= rxb_next;
			sup_reg <= sup_next;
			swd_reg <= swd_next;
			mdat_reg <= mdat_next;
			cstb_reg <= cstb_next;
			sstb_reg <= sstb_next;
			mstb_reg <= mstb_next;
		end
	end

	assign link.up = up_reg;
	assign proc_rdata_o = rdata_reg;
	assign par_err_o = err_reg;
	assign trunk_en_o = en_reg;
	assign receive_data_bus_o = rxb_reg;
	assign receive_sup_o = sup_reg;
	assign codec_trunk_o = ctrk_reg;
	assign codec_stb_o = cstb_reg;
	assign scan_trunk_o = scan_reg;
	assign scan_stb_o = sstb_reg;
	assign scan_wdata_o = swd_reg;
	assign msg_trunk_stb_o = mstb_reg[0];
	assign msg_net_stb_o = mstb_reg[1];
	assign msg_integ_stb_o = mstb_reg[2];
	assign msg_data_o = mdat_reg;
endmodule // tmc_trunk_end

// ---- tb/tmc_link_sva.sv ----
// Purpose: Assertions on the serial link between the network end and the trunk end.
// Assumes: One clock; the network end owns bit and frame timing.
// Notes: Upstream parity is checked on plane 0, sampled here at each strobe one bit after launch.
`timescale 1ns/10ps
module tmc_link_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Link
	input wire logic bit_stb,
	input wire logic frm_sync,
	input wire logic [1:0] dn,
	input wire logic [1:0] up
);
	logic [8:0] cnt_reg, cnt_next;
	logic [3:0] pos_reg, pos_next;
	logic acc_reg, acc_next, seen_reg, seen_next, full_reg, full_next;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// The parity sum starts one bit late because up changes one clock after each strobe, so a strobe sees the previous bit.
	always_comb begin
		cnt_next = cnt_reg;
		pos_next = pos_reg;
		acc_next = acc_reg;
		seen_next = seen_reg;
		full_next = full_reg;
		if (bit_stb) begin
			cnt_next = frm_sync ? 9'h000 : cnt_reg + 9'h001;
			pos_next = (frm_sync || pos_reg == 4'h9) ? 4'h0 : pos_reg + 4'h1;
			acc_next = (pos_next == 4'h1) ? up[0] : acc_reg ^ up[0];
			seen_next = seen_reg | frm_sync;
			full_next = full_reg | (seen_reg && pos_next == 4'h1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 9'h000;
			pos_reg <= 4'h0;
			acc_reg <= 1'b0;
			seen_reg <= 1'b0;
			full_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pos_reg <= pos_next;
			acc_reg <= acc_next;
			seen_reg <= seen_next;
			full_reg <= full_next;
		end
	end

	sequence s_bit_gap;
		##1 (!bit_stb) [*8] ##1 bit_stb;
	endsequence
	sequence s_dn_hold;
		##1 $stable(dn) [*8];
	endsequence
	sequence s_up_hold;
		##2 $stable(up) [*8];
	endsequence

	chk_strobe_gap: assert property (bit_stb |-> s_bit_gap)
		else $error("bit strobe spacing is not nine cycles");
	chk_sync_strobe: assert property (frm_sync |-> bit_stb)
		else $error("frame sync without bit strobe");
	chk_frame_len: assert property (bit_stb && frm_sync && seen_reg |-> cnt_reg == 9'h13F)
		else $error("frame is not 320 bits long");
	chk_sync_due: assert property (bit_stb && seen_reg && cnt_reg == 9'h13E |-> ##9 frm_sync)
		else $error("frame sync missing after last bit");
	chk_dn_hold: assert property (bit_stb |-> s_dn_hold)
		else $error("downstream data moved inside a bit");
	chk_up_hold: assert property (bit_stb |-> s_up_hold)
		else $error("upstream data moved inside a bit");
	chk_up_parity: assert property (bit_stb && full_reg && pos_next == 4'h0 |-> !(acc_reg ^ up[0]))
		else $error("upstream word parity is odd");
	chk_plane_copy: assert property (bit_stb |-> up[0] == up[1])
		else $error("planes carry different upstream bits");
endmodule // tmc_link_sva

// ---- tb/tb.sv ----
// Purpose: Self-checking bench joining the network end and the trunk end over the link.
// Assumes: 25 MHz clock; processor port driven by bench tasks.
// Notes: Frame number is tracked here from frame sync to predict scan and tone values.
`timescale 1ns/10ps
`define CMP(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
	import tmc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [4:0] net_ch_o, net_rx_ch_o, codec_trunk_o, scan_trunk_o;
	tmc_word_t net_tx_word_i = 9'h000;
	logic [1:0] net_par_flip_i = 2'h0;
	logic [1:0][8:0] net_rx_word_o;
	logic [1:0] net_rx_perr_o, par_err_o;
	logic [5:0] proc_addr_i = 6'h00;
	logic [7:0] proc_wdata_i = 8'h00;
	logic proc_wr_i = 1'b0;
	logic proc_rd_i = 1'b0;
	logic [7:0] proc_rdata_o, receive_data_bus_o, scan_wdata_o, msg_data_o;
	logic [N_TRUNK-1:0] trunk_en_o;
	logic [7:0] transmit_data_bus_i = 8'hC3;
	logic transmit_sup_i = 1'b1;
	logic [7:0] scan_rdata_i = 8'hA5;
	logic [7:0] card_id_i = 8'h3C;
	logic net_rx_stb_o, receive_sup_o, codec_stb_o, scan_stb_o;
	logic msg_trunk_stb_o, msg_net_stb_o, msg_integ_stb_o;
	tmc_word_t tx_tab [N_CH];
	logic [7:0] tone_tab [8] = '{8'h80, 8'hDA, 8'hFF, 8'hDA, 8'h80, 8'h25, 8'h00, 8'h25};
	logic [5:0] fr = 6'h00;
	logic synced = 1'b0;
	logic [8:0] sat_sum;
	int fail_count = 0;
	int checks = 0;

	tmc_link_if tmc_link_if_i ();
	tmc_network_end tmc_network_end_i (.ref_clk_i, .rst_b_i, .link(tmc_link_if_i), .net_ch_o, .net_tx_word_i,
		.net_par_flip_i, .net_rx_word_o, .net_rx_ch_o, .net_rx_stb_o, .net_rx_perr_o);
	tmc_trunk_end tmc_trunk_end_i (.ref_clk_i, .rst_b_i, .link(tmc_link_if_i), .proc_addr_i, .proc_wdata_i,
		.proc_wr_i, .proc_rd_i, .proc_rdata_o, .par_err_o, .trunk_en_o, .receive_data_bus_o, .receive_sup_o,
		.transmit_data_bus_i, .transmit_sup_i, .codec_trunk_o, .codec_stb_o, .scan_trunk_o, .scan_stb_o,
		.scan_wdata_o, .scan_rdata_i, .card_id_i, .msg_trunk_stb_o, .msg_net_stb_o, .msg_integ_stb_o, .msg_data_o);
	tmc_link_sva tmc_link_sva_i (.ref_clk_i, .rst_b_i, .bit_stb(tmc_link_if_i.bit_stb),
		.frm_sync(tmc_link_if_i.frm_sync), .dn(tmc_link_if_i.dn), .up(tmc_link_if_i.up));

	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		net_tx_word_i <= tx_tab[net_ch_o];
	end

	// Frame zero is the one that starts right after reset; the count wraps after forty frames.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fr <= 6'h00;
			synced <= 1'b0;
		end else if (tmc_link_if_i.bit_stb && tmc_link_if_i.frm_sync) begin
			fr <= (!synced || fr == FRM_LAST) ? 6'h00 : fr + 6'h01;
			synced <= 1'b1;
		end
	end

	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		proc_addr_i <= a;
		proc_wdata_i <= d;
		proc_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		proc_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk_i);
		proc_addr_i <= a;
		proc_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		proc_rd_i <= 1'b0;
		#1;
		`CMP(nm, e, proc_rdata_o)
	endtask

	function automatic logic hit(input int k, input logic [4:0] v);
		case (k)
			0: return tmc_link_if_i.frm_sync;
			1: return codec_stb_o && codec_trunk_o == v;
			2: return net_rx_stb_o && net_rx_ch_o == v;
			3: return scan_stb_o;
			default: return msg_trunk_stb_o | msg_net_stb_o | msg_integ_stb_o;
		endcase
	endfunction

	task automatic wait_on(input int k, input logic [4:0] v);
		int n = 0;
		@(posedge ref_clk_i);
		#1;
		while (hit(k, v) !== 1'b1 && n < 7000) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		if (n >= 7000) begin
			fail_count++;
			$display("CHECK FAILED wait_%0d expected event seen none", k);
			close_out();
		end
	endtask

	initial begin
		for (int c = 0; c < N_CH; c++) begin
			tx_tab[c] = {8'(8'h30 + c), c[0]};
		end
		tx_tab[0] = 9'h1FE;
		repeat (12) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(A_ERR, 8'h00, "err_reset");
		rd(A_PLANE, 8'h00, "plane_reset");
		rd(A_MAP + 6'h05, 8'h00, "map_reset");
		wr(A_MAP + 6'h05, 8'h23);
		wr(A_MAP + 6'h06, 8'h24);
		wr(A_MAP + 6'h09, 8'hFD);
		rd(A_MAP + 6'h09, 8'hFD, "map_rw");
		wait_on(0, 5'h00);
		wait_on(1, 5'h03);
		`CMP("rx_bus", 8'h35, receive_data_bus_o)
		`CMP("rx_sup", 1'b1, receive_sup_o)
		`CMP("trunk_en", 30'h0000008, trunk_en_o)
		wait_on(1, 5'h1D);
		`CMP("tone", tone_tab[fr[2:0]], receive_data_bus_o)
		`CMP("trunk_en_top", 30'h20000000, trunk_en_o)
		// Transmit words leave one frame after capture, so two frame starts are passed.
		wait_on(0, 5'h00);
		wait_on(0, 5'h00);
		wait_on(2, 5'h06);
		`CMP("tx_ch6", 8'hC3, net_rx_word_o[0][8:1])
		`CMP("tx_plane1", 8'hC3, net_rx_word_o[1][8:1])
		`CMP("tx_sup", 1'b1, net_rx_word_o[0][0])
		`CMP("rx_perr", 2'h0, net_rx_perr_o)
		wait_on(2, 5'h07);
		`CMP("idle_ch7", 9'h1FE, net_rx_word_o[0])
		wr(A_LOOP, 8'h08);
		wait_on(0, 5'h00);
		wait_on(0, 5'h00);
		wait_on(2, 5'h05);
		`CMP("loop_ch5", 8'h35, net_rx_word_o[0][8:1])
		wait_on(2, 5'h06);
		`CMP("noloop_ch6", 8'hC3, net_rx_word_o[0][8:1])
		wr(A_LOOP, 8'h00);
		for (int t = 0; t < 3; t++) begin
			tx_tab[0] = {2'(t), 6'h15, 1'b0};
			wait_on(4, 5'h00);
			`CMP("msg_kind", 3'(1 << t), {msg_integ_stb_o, msg_net_stb_o, msg_trunk_stb_o})
			`CMP("msg_data", {2'(t), 6'h15}, msg_data_o)
		end
		rd(A_MSG0, 8'h95, "msg_reg");
		rd(A_MSG1, 8'h95, "msg_plane1");
		tx_tab[0] = 9'h1FE;
		wr(A_TXMSG, 8'h96);
		rd(A_TXMSG, 8'h01, "tx_pend");
		// The control channel now ending went out idle; the message rides the next frame's one.
		wait_on(0, 5'h00);
		wait_on(2, 5'h00);
		`CMP("tx_msg", 8'h96, net_rx_word_o[0][8:1])
		rd(A_TXMSG, 8'h00, "tx_sent");
		@(posedge ref_clk_i);
		net_par_flip_i <= 2'h2;
		repeat (100) @(posedge ref_clk_i);
		net_par_flip_i <= 2'h0;
		repeat (200) @(posedge ref_clk_i);
		#1;
		`CMP("par_flag", 2'h2, par_err_o)
		rd(A_ERR, 8'h02, "err_read");
		wr(A_ERR, 8'h02);
		rd(A_ERR, 8'h00, "err_clear");
		for (int k = 0; k < 2; k++) begin
			wait_on(3, 5'h00);
			`CMP("scan_trunk", fr[4:0], scan_trunk_o)
			`CMP("scan_wdata", 8'h40, scan_wdata_o)
		end
		rd(A_CARD, 8'h3C, "card_id");
		rd(A_SCAN, {3'h0, fr[4:0]}, "scan_reg");
		wait_on(2, 5'h10);
		`CMP("scan_rdata", 8'hA5, net_rx_word_o[0][8:1])
		// Plane one selected and channel six switched to a saturating tone add.
		wr(A_PLANE, 8'h01);
		rd(A_PLANE, 8'h01, "plane_sel");
		wr(A_MAP + 6'h06, 8'h64);
		wait_on(1, 5'h04);
		sat_sum = 9'(tone_tab[fr[2:0]]) + 9'h036;
		`CMP("rx_sat", sat_sum[8] ? 8'hFF : sat_sum[7:0], receive_data_bus_o)
		`CMP("sup_plane1", 1'b0, receive_sup_o)
		close_out();
	end
endmodule // tb
